//--- dac_twowire_pkg.sv
// constants and link states of the two-wire slave port
package dac_twowire_pkg;
	// =====================================================
	// address and bus codes
	localparam logic [3:0] ADDR_PREFIX = 4'h9;
	localparam logic [4:0] MCODE_PREFIX = 5'h01;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// =====================================================
	// timing
	localparam int CLK_NS = 25;
	localparam int SPIKE_FS_NS = 50;
	localparam int SPIKE_HS_NS = 10;
	localparam logic [2:0] FILT_FS_CYC = 3'(SPIKE_FS_NS / CLK_NS + 1);
	localparam logic [2:0] FILT_HS_CYC = 3'(SPIKE_HS_NS / CLK_NS + 1);
	// =====================================================
	// receive buffer and code
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 16;
	localparam int CODE_BITS_DEF = 12;
	localparam bit LARGE_PKG_DEF = 1'b1;
	// =====================================================
	// link states
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ACK,
		S_RX,
		S_TX,
		S_TXACK,
		S_IGNORE
	} link_state_t;
endpackage

//--- rx_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} fifo_state_t;
	fifo_state_t fifo_reg;
	fifo_state_t fifo_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// =====================================================
	// flags and pointers
	assign in_ready = (fifo_reg.wptr[AW-1:0] != fifo_reg.rptr[AW-1:0]) ||
		(fifo_reg.wptr[AW] == fifo_reg.rptr[AW]);
	assign out_valid = fifo_reg.wptr != fifo_reg.rptr;
	assign out_data = mem[fifo_reg.rptr[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		fifo_next = fifo_reg;
		if (push) begin
			fifo_next.wptr = fifo_reg.wptr + 1'b1;
		end
		if (pop) begin
			fifo_next.rptr = fifo_reg.rptr + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[fifo_reg.wptr[AW-1:0]] <= in_data;
		end
	end
endmodule

//--- dac_twowire_slave.sv
// two-wire serial slave front end of an octal converter
//
// Notes on behaviour
// R1 - data line only pulled low or released; never driven high.
// R2 - master makes every clock pulse; this port only watches the clock.
// R3 - start is data falling while clock high; detected in any state.
// R4 - master sends seven address bits then a direction bit.
// R5 - transmitter holds data stable while clock high; changes when low.
// R6 - acknowledge only a matching address, low through ninth clock high.
// R7 - acknowledge is data low at ninth clock high; released is no-ack.
// R8 - direction 0 means master writes; 1 means this port transmits.
// R9 - receiver of each data byte acknowledges it; this port gives no-ack when its receive buffer is full.
// R10 - eight data bits plus acknowledge repeat until stop or restart.
// R11 - normally receiver; becomes transmitter when master reads.
// R12 - stop is data rising while clock high; detected in any state.
// R13 - after stop, ignore traffic until start plus matching address.
// R14 - seven-bit addressing only; no ten-bit or general call ack.
// R15 - works at 100k, 400k, 1M and 3.4M bits per second.
// R16 - master code 00001xxx is not acknowledged but enters high speed.
// R17 - after master code a repeated start resumes normal protocol.
// R18 - stop ends high speed and restores normal settings.
// R19 - master should chain repeated starts to stay in high speed.
// R20 - small package always binary; large package pin picks format.
// R21 - code is unsigned 8, 10 or 12 bits, full scale 255/1023/4095.
// R22 - address is 1001 followed by three address-select pin bits.
// R23 - lines synchronised and filtered before detecting conditions.
`timescale 1ns/1ps
module dac_twowire_slave
	import dac_twowire_pkg::*;
#(
	parameter int CODE_BITS = CODE_BITS_DEF,
	parameter bit LARGE_PKG = LARGE_PKG_DEF
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [2:0] ADDR_SEL,
	input wire logic CODE_FORMAT_SELECT,
	output logic CODE_TWOS,
	output logic [15:0] CODE_FULL_SCALE,
	output logic HS_ACTIVE,
	output logic ADDRESSED,
	output logic [7:0] RX_DATA,
	output logic RX_FIRST,
	output logic RX_VALID,
	input wire logic RX_READY,
	input wire logic [7:0] TX_DATA,
	output logic TX_TAKEN
);
	// =====================================================
	// state record
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		logic [2:0] addr_s1;
		logic [2:0] addr_s2;
		logic fmt_s1;
		logic fmt_s2;
		logic scl_f;
		logic sda_f;
		logic [2:0] scl_cnt;
		logic [2:0] sda_cnt;
		link_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rw;
		logic hs;
		logic first;
		logic master_ack;
		logic sda_oe;
		logic push;
		logic [8:0] push_data;
		logic tx_taken;
		logic twos;
		logic [15:0] full_scale;
	} slave_state_t;

	slave_state_t state_reg;
	slave_state_t state_next;
	logic [2:0] filt_lim;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic fifo_ready;
	logic [8:0] fifo_out;

	// =====================================================
	// glitch filter step: returns {value, count}
	function automatic logic [3:0] filt_step(input logic raw,
		input logic val, input logic [2:0] cnt, input logic [2:0] lim);
		if (raw == val) begin
			return {val, 3'h0};
		end else if (cnt + 3'h1 >= lim) begin
			return {raw, 3'h0};
		end else begin
			return {val, cnt + 3'h1};
		end
	endfunction

	// =====================================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.push = 1'b0;
		state_next.tx_taken = 1'b0;
		// pins pass two flip-flops first
		state_next.scl_s1 = SCL_IN;
		state_next.scl_s2 = state_reg.scl_s1;
		state_next.sda_s1 = SDA_IN;
		state_next.sda_s2 = state_reg.sda_s1;
		state_next.addr_s1 = ADDR_SEL;
		state_next.addr_s2 = state_reg.addr_s1;
		state_next.fmt_s1 = CODE_FORMAT_SELECT;
		state_next.fmt_s2 = state_reg.fmt_s1;
		// shorter filter in high speed to keep 3.4M bit times
		filt_lim = state_reg.hs ? FILT_HS_CYC : FILT_FS_CYC; // see R15
		{state_next.scl_f, state_next.scl_cnt} = filt_step(
			state_reg.scl_s2, state_reg.scl_f, state_reg.scl_cnt,
			filt_lim); // see R23
		{state_next.sda_f, state_next.sda_cnt} = filt_step(
			state_reg.sda_s2, state_reg.sda_f, state_reg.sda_cnt,
			filt_lim); // see R23
		// clock is only observed, never driven
		scl_rise = state_next.scl_f & ~state_reg.scl_f; // see R2
		scl_fall = ~state_next.scl_f & state_reg.scl_f;
		start_det = state_reg.scl_f & state_next.scl_f &
			state_reg.sda_f & ~state_next.sda_f; // see R3
		stop_det = state_reg.scl_f & state_next.scl_f &
			~state_reg.sda_f & state_next.sda_f; // see R12
		state_next.twos = LARGE_PKG ? state_reg.fmt_s2 : 1'b0; // see R20
		state_next.full_scale = 16'((32'h1 << CODE_BITS) - 1); // see R21

		if (stop_det) begin
			state_next.st = S_IDLE; // see R13
			state_next.sda_oe = 1'b0;
			state_next.hs = 1'b0; // see R18
		end else if (start_det) begin
			// repeated start keeps high speed
			state_next.st = S_ADDR; // see R17
			state_next.bit_cnt = 4'h0;
			state_next.sda_oe = 1'b0;
		end else begin
			unique case (state_reg.st)
			S_IDLE, S_IGNORE: begin
				state_next.sda_oe = 1'b0; // see R13
			end
			S_ADDR, S_RX: begin
				if (scl_rise) begin
					state_next.shift = {state_reg.shift[6:0],
						state_reg.sda_f}; // see R5
					state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
				end else if (scl_fall &&
					state_reg.bit_cnt == BITS_PER_BYTE) begin
					state_next.bit_cnt = 4'h0;
					if (state_reg.st == S_ADDR) begin
						if (state_reg.shift[7:3] == MCODE_PREFIX) begin
							state_next.hs = 1'b1; // see R16
							state_next.st = S_IGNORE; // see R16
						end else if (state_reg.shift[7:1] ==
							{ADDR_PREFIX, state_reg.addr_s2}) begin
							// other addresses incl. ten-bit and 0 miss
							state_next.sda_oe = 1'b1; // see R6, R14, R22
							state_next.rw = state_reg.shift[0]; // see R4
							state_next.first = 1'b1;
							state_next.st = S_ACK;
						end else begin
							state_next.st = S_IGNORE; // see R14
						end
					end else begin
						// full buffer answers with a not-acknowledge
						state_next.sda_oe = fifo_ready; // see R9, R7
						state_next.push = fifo_ready;
						state_next.push_data = {state_reg.first,
							state_reg.shift};
						state_next.first = 1'b0;
						state_next.st = fifo_ready ? S_ACK : S_IGNORE;
					end
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					state_next.bit_cnt = 4'h0;
					if (state_reg.rw) begin
						state_next.st = S_TX; // see R8, R11
						state_next.shift = TX_DATA;
						state_next.tx_taken = 1'b1;
						state_next.sda_oe = ~TX_DATA[7]; // see R1
					end else begin
						state_next.st = S_RX; // see R8, R10
						state_next.sda_oe = 1'b0;
					end
				end
			end
			S_TX: begin
				if (scl_rise) begin
					state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
				end else if (scl_fall) begin
					if (state_reg.bit_cnt == BITS_PER_BYTE) begin
						state_next.sda_oe = 1'b0;
						state_next.st = S_TXACK;
					end else begin
						state_next.shift = {state_reg.shift[6:0], 1'b0};
						state_next.sda_oe = ~state_reg.shift[6]; // see R5
					end
				end
			end
			S_TXACK: begin
				if (scl_rise) begin
					state_next.master_ack = ~state_reg.sda_f; // see R9
				end else if (scl_fall) begin
					state_next.bit_cnt = 4'h0;
					if (state_reg.master_ack) begin
						state_next.st = S_TX; // see R10
						state_next.shift = TX_DATA;
						state_next.tx_taken = 1'b1;
						state_next.sda_oe = ~TX_DATA[7];
					end else begin
						state_next.st = S_IGNORE; // see R7
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// =====================================================
	// receive buffer
	rx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.in_valid(state_reg.push),
		.in_ready(fifo_ready),
		.in_data(state_reg.push_data),
		.out_valid(RX_VALID),
		.out_ready(RX_READY),
		.out_data(fifo_out)
	);

	// =====================================================
	// outputs
	assign SDA_OUT = 1'b0; // see R1
	assign SDA_OE = state_reg.sda_oe;
	assign CODE_TWOS = state_reg.twos;
	assign CODE_FULL_SCALE = state_reg.full_scale;
	assign HS_ACTIVE = state_reg.hs;
	assign ADDRESSED = (state_reg.st != S_IDLE) &&
		(state_reg.st != S_IGNORE) && (state_reg.st != S_ADDR);
	assign RX_DATA = fifo_out[7:0];
	assign RX_FIRST = fifo_out[8];
	assign TX_TAKEN = state_reg.tx_taken;
endmodule

//--- dac_twowire_assertions.sv
// pin-level assertions for the two-wire slave port
`timescale 1ns/1ps
module dac_twowire_assertions
	import dac_twowire_pkg::*;
#(
	parameter int CODE_BITS = 12,
	parameter bit LARGE_PKG = 1'b1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic [2:0] ADDR_SEL,
	input wire logic CODE_FORMAT_SELECT,
	input wire logic CODE_TWOS,
	input wire logic [15:0] CODE_FULL_SCALE,
	input wire logic HS_ACTIVE,
	input wire logic ADDRESSED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// =====================================================
	// bits seen at clock rises, cycles since clock fall
	logic [7:0] sh_reg;
	logic [3:0] fall_reg;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sh_reg <= 8'h00;
			fall_reg <= 4'h0;
		end else begin
			if ($rose(SCL_IN))
				sh_reg <= {sh_reg[6:0], SDA_IN};
			fall_reg <= $fell(SCL_IN) ? 4'h0 : fall_reg + 4'(fall_reg != 4'hf);
		end
	end
	sequence stop_s;
		SCL_IN && $rose(SDA_IN);
	endsequence
	sequence start_s;
		SCL_IN && $fell(SDA_IN);
	endsequence
	sda_low_only_a: assert property (SDA_OUT == 1'b0)
		else $error("data line driven high");
	full_scale_a: assert property ($past(RST_N) |->
		CODE_FULL_SCALE == 16'((1 << CODE_BITS) - 1)) else $error("bad scale");
	code_format_a: assert property ($stable(CODE_FORMAT_SELECT) [*8] |->
		CODE_TWOS == (LARGE_PKG && CODE_FORMAT_SELECT)) else $error("bad format");
	oe_after_fall_a: assert property ($rose(SDA_OE) |->
		fall_reg == (HS_ACTIVE ? 4'h2 : 4'h4)) else $error("pull not after fall");
	addr_match_a: assert property ($rose(ADDRESSED) |->
		sh_reg[7:1] == {ADDR_PREFIX, ADDR_SEL}) else $error("wrong address");
	hs_no_ack_a: assert property ($rose(HS_ACTIVE) |-> !SDA_OE [*8])
		else $error("master code acknowledged");
	hs_exit_a: assert property (stop_s |-> ##10 !HS_ACTIVE)
		else $error("high speed kept after stop");
	stop_release_a: assert property (stop_s |-> ##10 !ADDRESSED && !SDA_OE)
		else $error("bus held after stop");
	restart_a: assert property (start_s |-> ##10 !ADDRESSED)
		else $error("start not seen");
endmodule
bind dac_twowire_slave dac_twowire_assertions #(.CODE_BITS(CODE_BITS),
	.LARGE_PKG(LARGE_PKG)) chk_u (.CLK, .RST_N, .SCL_IN, .SDA_IN, .SDA_OUT,
	.SDA_OE, .ADDR_SEL, .CODE_FORMAT_SELECT, .CODE_TWOS, .CODE_FULL_SCALE,
	.HS_ACTIVE, .ADDRESSED);

//--- twowire_master.sv
// bus master model driving the clock and data lines
`timescale 1ns/1ps
module twowire_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// =====================================================
	// bus cycles, half bit time of eight system clocks
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start_cond();
		sda_low <= 1'b0;
		step(8);
		scl <= 1'b1;
		step(4);
		sda_low <= 1'b1;
		step(4);
		scl <= 1'b0;
	endtask
	task automatic put_bit(input logic b, output logic r);
		step(7);
		sda_low <= !b;
		step(1);
		scl <= 1'b1;
		step(4);
		r = sda;
		step(4);
		scl <= 1'b0;
	endtask
	task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
			output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], r);
			q[i] = r;
		end
		put_bit(!ack_in, r);
		ack = !r;
	endtask
	task automatic stop_cond();
		step(7);
		sda_low <= 1'b1;
		step(1);
		scl <= 1'b1;
		step(4);
		sda_low <= 1'b0;
		step(8);
	endtask
endmodule

//--- dac_twowire_slave_test.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module dac_twowire_slave_test
	import dac_twowire_pkg::*;
;
	logic clk, rst_n = 1'b0, fmt = 1'b1, rx_ready = 1'b0, stall = 1'b0;
	logic scl, sda_low, sda_out, sda_oe, code_twos, hs_active, addressed;
	logic rx_first, rx_valid, tx_taken, a;
	logic [15:0] code_full_scale;
	logic [7:0] rx_data, q, tx_data, txv[4];
	logic [2:0] addr_sel, sel;
	logic [6:0] bad[3];
	logic [8:0] rxq[$];
	logic [31:0] seed = 32'ha30d;
	int num_errors = 0;
	int compares = 0;
	int tk = 0;
	wire sda_w = (sda_oe ? sda_out : 1'b1) && !sda_low;
	dac_twowire_slave dut_u (.CLK(clk), .RST_N(rst_n), .SCL_IN(scl),
		.SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
		.CODE_FORMAT_SELECT(fmt), .CODE_TWOS(code_twos),
		.CODE_FULL_SCALE(code_full_scale), .HS_ACTIVE(hs_active),
		.ADDRESSED(addressed), .RX_DATA(rx_data), .RX_FIRST(rx_first),
		.RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data),
		.TX_TAKEN(tx_taken));
	twowire_master m_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// =====================================================
	// shared tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [15:0] v, input logic [15:0] e);
		compares++;
		if (v !== e) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, v, e);
		end
	endtask
	task automatic results();
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [6:0] ad, input int n, input int acks);
		logic [7:0] d;
		m_u.start_cond();
		m_u.byte_xfer({ad, 1'b0}, 1'b0, q, a);
		check(a, ad == {ADDR_PREFIX, sel});
		for (int i = 0; i < n; i++) begin
			d = 8'(rnd());
			// note goes in before the byte: the receive check may pop it mid-ack
			if (i < acks)
				rxq.push_back({i == 0, d});
			m_u.byte_xfer(d, 1'b0, q, a);
			check(a, i < acks);
		end
		m_u.stop_cond();
	endtask
	// =====================================================
	// receive side checks and transmit byte supply
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check({rx_first, rx_data}, rxq.size() ? rxq.pop_front() : 'x);
		rx_ready <= !stall && !rx_ready;
		if (tx_taken === 1'b1) begin
			tk <= tk + 1;
			tx_data <= txv[tk + 1];
		end
	end
	// =====================================================
	// main sequence
	initial begin
		sel = 3'(rnd());
		addr_sel = sel;
		for (int i = 0; i < 4; i++)
			txv[i] = 8'(rnd());
		tx_data = txv[0];
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		check(code_full_scale, 16'h0fff);
		check(code_twos, 1'b1);
		fmt <= 1'b0;
		repeat (10) @(posedge clk);
		check(code_twos, 1'b0);
		stall = 1'b1;
		wr({ADDR_PREFIX, sel}, 17, 16);
		stall = 1'b0;
		for (int k = 0; rxq.size() != 0 && k < 400; k++)
			@(posedge clk);
		check(rxq.size(), 16'h0000);
		bad = '{{ADDR_PREFIX, ~sel}, 7'h00, 7'h78};
		for (int i = 0; i < 3; i++)
			wr(bad[i], 0, 0);
		m_u.start_cond();
		m_u.byte_xfer({ADDR_PREFIX, sel, 1'b1}, 1'b0, q, a);
		check(a, 1'b1);
		for (int i = 0; i < 3; i++) begin
			m_u.byte_xfer(8'hff, i < 2, q, a);
			check(q, txv[i]);
		end
		m_u.stop_cond();
		m_u.start_cond();
		m_u.byte_xfer({MCODE_PREFIX, 3'(rnd())}, 1'b0, q, a);
		check(a, 1'b0);
		check(hs_active, 1'b1);
		wr({ADDR_PREFIX, sel}, 2, 2);
		check(hs_active, 1'b0);
		for (int k = 0; rxq.size() != 0 && k < 400; k++)
			@(posedge clk);
		check(rxq.size(), 16'h0000);
		results();
	end
endmodule
